// file: core/instr_decoder.v
// Decoder for accumulator memory-reference and pointer/page instructions.
// Assumes a fetch stage on the same clock offering one word per valid cycle.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_consts.vh"

module instr_decoder (
  input wire clk,
  input wire rst_b,
  input wire word_valid,
  input wire [15:0] word_in,
  input wire [8:0] page_pointer,
  input wire [2:0] current_ptr_select,
  output reg issue_valid,
  output reg [5:0] op_code,
  output reg [1:0] word_count,
  output reg foreign_word,
  output reg operand_next,
  output reg indirect_mode,
  output reg [6:0] addr_field,
  output reg [15:0] direct_addr,
  output reg [2:0] ptr_select,
  output reg [3:0] shift_code,
  output reg [15:0] imm_value,
  output reg [1:0] compare_mode_field
);

  localparam ST_OPCODE = 2'b01;
  localparam ST_OPERAND = 2'b10;

  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Combinational classification of one opcode word
  reg [5:0] dec_op;
  reg dec_long;
  reg [2:0] dec_reg_sel;
  reg [15:0] dec_imm;
  always @* begin
    dec_op = `OP_NONE;
    dec_long = 1'b0;
    dec_reg_sel = current_ptr_select;
    dec_imm = 16'h0000;
    if (word_in == `WORD_CLEAR_ACC) begin
      dec_op = `OP_CLEAR_ACC;
    end else if (word_in[15:12] == `NIB_SUM_SHIFTED) begin
      dec_op = `OP_SUM_SHIFTED_MEM;
    end else if (word_in[15:12] == `NIB_MINUS_SHIFTED) begin
      dec_op = `OP_MINUS_SHIFTED_MEM;
    end else if (word_in[15:12] == `NIB_FETCH_SHIFTED) begin
      dec_op = `OP_FETCH_SHIFTED_MEM;
    end else if (word_in[15:12] == `NIB_LONG_IMM && word_in[7:0] >= `LOW_FETCH_LONG &&
                 word_in[7:0] <= `LOW_XDISJ_LONG) begin
      dec_long = 1'b1;
      if (word_in[7:0] == `LOW_FETCH_LONG) begin
        dec_op = `OP_FETCH_LONG_IMM;
      end else if (word_in[7:0] == `LOW_SUM_LONG) begin
        dec_op = `OP_SUM_LONG_IMM;
      end else if (word_in[7:0] == `LOW_MINUS_LONG) begin
        dec_op = `OP_MINUS_LONG_IMM;
      end else if (word_in[7:0] == `LOW_CONJ_LONG) begin
        dec_op = `OP_CONJ_LONG_IMM;
      end else if (word_in[7:0] == `LOW_DISJ_LONG) begin
        dec_op = `OP_DISJ_LONG_IMM;
      end else begin
        dec_op = `OP_XDISJ_LONG_IMM;
      end
    end else if (word_in[15:11] == `TOP5_LOAD_PTR_LONG && word_in[7:0] == `LOW_ZERO) begin
      dec_op = `OP_LOAD_PTR_REG_LONG;
      dec_long = 1'b1;
      dec_reg_sel = word_in[10:8];
    end else if (word_in[15:8] == `HB_SUM_SHORT) begin
      dec_op = `OP_SUM_SHORT_IMM;
      dec_imm = {8'h00, word_in[7:0]};
    end else if (word_in[15:8] == `HB_MINUS_SHORT) begin
      dec_op = `OP_MINUS_SHORT_IMM;
      dec_imm = {8'h00, word_in[7:0]};
    end else if (word_in[15:8] == `HB_FETCH_SHORT) begin
      dec_op = `OP_FETCH_SHORT_IMM;
      dec_imm = {8'h00, word_in[7:0]};
    end else if (word_in[15:8] == `HB_CLEAR_FETCH_HIGH) begin
      dec_op = `OP_CLEAR_FETCH_HIGH;
    end else if (word_in[15:8] == `HB_CLEAR_FETCH_LOW_U) begin
      dec_op = `OP_CLEAR_FETCH_LOW_U;
    end else if (word_in[15:8] == `HB_FETCH_TSHIFT) begin
      dec_op = `OP_FETCH_TSHIFT_MEM;
    end else if (word_in[15:8] == `HB_SUM_CARRY) begin
      dec_op = `OP_SUM_CARRY_MEM;
    end else if (word_in[15:8] == `HB_MINUS_HIGH) begin
      dec_op = `OP_MINUS_HIGH_MEM;
    end else if (word_in[15:8] == `HB_MINUS_LOW_U) begin
      dec_op = `OP_MINUS_LOW_U;
    end else if (word_in[15:8] == `HB_MINUS_TSHIFT) begin
      dec_op = `OP_MINUS_TSHIFT_MEM;
    end else if (word_in[15:8] == `HB_COND_MINUS) begin
      dec_op = `OP_COND_MINUS_MEM;
    end else if (word_in[15:8] == `HB_SUM_HIGH) begin
      dec_op = `OP_SUM_HIGH_MEM;
    end else if (word_in[15:8] == `HB_SUM_LOW_U) begin
      dec_op = `OP_SUM_LOW_U;
    end else if (word_in[15:8] == `HB_SUM_TSHIFT) begin
      dec_op = `OP_SUM_TSHIFT_MEM;
    end else if (word_in[15:8] == `HB_XDISJ_MEM) begin
      dec_op = `OP_XDISJ_MEM;
    end else if (word_in[15:8] == `HB_DISJ_MEM) begin
      dec_op = `OP_DISJ_MEM;
    end else if (word_in[15:8] == `HB_CONJ_MEM) begin
      dec_op = `OP_CONJ_MEM;
    end else if (word_in[15:8] == `HB_MINUS_BORROW) begin
      dec_op = `OP_MINUS_BORROW_MEM;
    end else if (word_in[15:8] == `HB_CLEAR_FETCH_HIGH_ROUND) begin
      dec_op = `OP_CLEAR_FETCH_HIGH_ROUND;
    end else if (word_in[15:11] == `TOP5_SAVE_HIGH) begin
      dec_op = `OP_SAVE_HIGH_ACC;
    end else if (word_in[15:11] == `TOP5_SAVE_LOW) begin
      dec_op = `OP_SAVE_LOW_ACC;
    end else if (word_in == `WORD_MAGNITUDE) begin
      dec_op = `OP_MAGNITUDE;
    end else if (word_in == `WORD_INVERT_ACC) begin
      dec_op = `OP_INVERT_ACC;
    end else if (word_in == `WORD_SIGN_FLIP) begin
      dec_op = `OP_SIGN_FLIP;
    end else if (word_in == `WORD_ROTATE_LEFT) begin
      dec_op = `OP_ROTATE_LEFT;
    end else if (word_in == `WORD_ROTATE_RIGHT) begin
      dec_op = `OP_ROTATE_RIGHT;
    end else if (word_in == `WORD_SHIFT_LEFT) begin
      dec_op = `OP_SHIFT_LEFT;
    end else if (word_in == `WORD_SHIFT_RIGHT) begin
      dec_op = `OP_SHIFT_RIGHT;
    end else if (word_in[15:11] == `TOP5_LOAD_PTR_MEM) begin
      dec_op = `OP_LOAD_PTR_REG_MEM;
      dec_reg_sel = word_in[10:8];
    end else if (word_in[15:11] == `TOP5_SAVE_PTR_MEM) begin
      dec_op = `OP_SAVE_PTR_REG_MEM;
      dec_reg_sel = word_in[10:8];
    end else if (word_in[15:11] == `TOP5_LOAD_PTR_SHORT) begin
      dec_op = `OP_LOAD_PTR_REG_SHORT;
      dec_reg_sel = word_in[10:8];
      dec_imm = {8'h00, word_in[7:0]};
    end else if (word_in[15:8] == `HB_BUMP_PTR) begin
      dec_op = `OP_BUMP_PTR_REG_IMM;
      dec_imm = {8'h00, word_in[7:0]};
    end else if (word_in[15:3] == `TOP13_SELECT_PTR) begin
      // Must precede the 55 match: it shares that high byte
      dec_op = `OP_SELECT_PTR_IMM;
      dec_reg_sel = word_in[2:0];
      dec_imm = {13'h0000, word_in[2:0]};
    end else if (word_in[15:8] == `HB_PTR_MODIFY) begin
      dec_op = `OP_PTR_MODIFY;
    end else if (word_in[15:8] == `HB_PAGE_LOAD_MEM) begin
      dec_op = `OP_PAGE_LOAD_MEM;
    end else if (word_in[15:9] == `TOP7_PAGE_LOAD_IMM) begin
      dec_op = `OP_PAGE_LOAD_IMM;
      dec_imm = {7'h00, word_in[8:0]};
    end else if (word_in[15:2] == `TOP14_PTR_COMPARE) begin
      dec_op = `OP_PTR_COMPARE;
    end
  end

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] held_word_reg;
  reg [5:0] held_op_reg;
  reg [2:0] held_sel_reg;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OPCODE: begin
        if (word_valid && dec_long) begin
          state_next = ST_OPERAND;
        end
      end
      ST_OPERAND: begin
        if (word_valid) begin
          state_next = ST_OPCODE;
        end
      end
      default: begin
        state_next = ST_OPCODE;
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= ST_OPCODE;
      held_word_reg <= 16'h0000;
      held_op_reg <= `OP_NONE;
      held_sel_reg <= 3'h0;
      issue_valid <= 1'b0;
      op_code <= `OP_NONE;
      word_count <= `LEN_ONE;
      foreign_word <= 1'b0;
      operand_next <= 1'b0;
      indirect_mode <= 1'b0;
      addr_field <= 7'h00;
      direct_addr <= 16'h0000;
      ptr_select <= 3'h0;
      shift_code <= 4'h0;
      imm_value <= 16'h0000;
      compare_mode_field <= 2'h0;
    end else begin
      state_reg <= state_next;
      issue_valid <= 1'b0;
      foreign_word <= 1'b0;
      if (state_reg == ST_OPERAND && word_valid) begin
        // Operand word completes the held long instruction
        issue_valid <= 1'b1;
        operand_next <= 1'b0;
        op_code <= held_op_reg;
        word_count <= `LEN_TWO;
        imm_value <= word_in;
        shift_code <= held_word_reg[11:8];
        ptr_select <= held_sel_reg;
        indirect_mode <= 1'b0;
        addr_field <= 7'h00;
        direct_addr <= 16'h0000;
        compare_mode_field <= 2'h0;
      end else if (state_reg == ST_OPCODE && word_valid) begin
        held_word_reg <= word_in;
        held_op_reg <= dec_op;
        held_sel_reg <= dec_reg_sel;
        indirect_mode <= word_in[7];
        addr_field <= word_in[6:0];
        direct_addr <= {page_pointer, word_in[6:0]};
        ptr_select <= dec_reg_sel;
        compare_mode_field <= word_in[1:0];
        imm_value <= dec_imm;
        if (dec_op == `OP_SAVE_HIGH_ACC || dec_op == `OP_SAVE_LOW_ACC) begin
          shift_code <= {1'b0, word_in[10:8]};
        end else begin
          shift_code <= word_in[11:8];
        end
        if (dec_long) begin
          operand_next <= 1'b1;
        end else begin
          issue_valid <= (dec_op != `OP_NONE);
          foreign_word <= (dec_op == `OP_NONE);
          op_code <= dec_op;
          word_count <= `LEN_ONE;
        end
      end
    end
  end

endmodule // instr_decoder
`default_nettype wire

// file: core/decoder_consts.vh
// Constants for the accumulator and pointer-register instruction decoder.
// Included by the decoder; definitions only.
`ifndef DECODER_CONSTS_VH
`define DECODER_CONSTS_VH

// Operation codes presented on op_code
`define OP_NONE              6'h00
`define OP_SUM_SHIFTED_MEM   6'h01
`define OP_MINUS_SHIFTED_MEM 6'h02
`define OP_FETCH_SHIFTED_MEM 6'h03
`define OP_FETCH_LONG_IMM    6'h04
`define OP_SUM_LONG_IMM      6'h05
`define OP_MINUS_LONG_IMM    6'h06
`define OP_CONJ_LONG_IMM     6'h07
`define OP_DISJ_LONG_IMM     6'h08
`define OP_XDISJ_LONG_IMM    6'h09
`define OP_SUM_SHORT_IMM     6'h0a
`define OP_MINUS_SHORT_IMM   6'h0b
`define OP_FETCH_SHORT_IMM   6'h0c
`define OP_CLEAR_ACC         6'h0d
`define OP_CLEAR_FETCH_HIGH  6'h0e
`define OP_CLEAR_FETCH_LOW_U 6'h0f
`define OP_FETCH_TSHIFT_MEM  6'h10
`define OP_SUM_CARRY_MEM     6'h11
`define OP_MINUS_HIGH_MEM    6'h12
`define OP_MINUS_LOW_U       6'h13
`define OP_MINUS_TSHIFT_MEM  6'h14
`define OP_COND_MINUS_MEM    6'h15
`define OP_SUM_HIGH_MEM      6'h16
`define OP_SUM_LOW_U         6'h17
`define OP_SUM_TSHIFT_MEM    6'h18
`define OP_XDISJ_MEM         6'h19
`define OP_DISJ_MEM          6'h1a
`define OP_CONJ_MEM          6'h1b
`define OP_MINUS_BORROW_MEM  6'h1c
`define OP_CLEAR_FETCH_HIGH_ROUND 6'h1d
`define OP_SAVE_HIGH_ACC     6'h1e
`define OP_SAVE_LOW_ACC      6'h1f
`define OP_MAGNITUDE         6'h20
`define OP_INVERT_ACC        6'h21
`define OP_SIGN_FLIP         6'h22
`define OP_ROTATE_LEFT       6'h23
`define OP_ROTATE_RIGHT      6'h24
`define OP_SHIFT_LEFT        6'h25
`define OP_SHIFT_RIGHT       6'h26
`define OP_LOAD_PTR_REG_MEM  6'h27
`define OP_SAVE_PTR_REG_MEM  6'h28
`define OP_LOAD_PTR_REG_SHORT 6'h29
`define OP_LOAD_PTR_REG_LONG 6'h2a
`define OP_BUMP_PTR_REG_IMM  6'h2b
`define OP_PTR_MODIFY        6'h2c
`define OP_SELECT_PTR_IMM    6'h2d
`define OP_PAGE_LOAD_MEM     6'h2e
`define OP_PAGE_LOAD_IMM     6'h2f
`define OP_PTR_COMPARE       6'h30

// Opcode fields and patterns
`define NIB_SUM_SHIFTED      4'h0
`define NIB_MINUS_SHIFTED    4'h1
`define NIB_FETCH_SHIFTED    4'h2
`define NIB_LONG_IMM         4'hd
`define LOW_FETCH_LONG       8'h01
`define LOW_SUM_LONG         8'h02
`define LOW_MINUS_LONG       8'h03
`define LOW_CONJ_LONG        8'h04
`define LOW_DISJ_LONG        8'h05
`define LOW_XDISJ_LONG       8'h06
`define HB_SUM_SHORT         8'hcc
`define HB_MINUS_SHORT       8'hcd
`define HB_FETCH_SHORT       8'hca
`define WORD_CLEAR_ACC       16'hca00
`define HB_CLEAR_FETCH_HIGH  8'h40
`define HB_CLEAR_FETCH_LOW_U 8'h41
`define HB_FETCH_TSHIFT      8'h42
`define HB_SUM_CARRY         8'h43
`define HB_MINUS_HIGH        8'h44
`define HB_MINUS_LOW_U       8'h45
`define HB_MINUS_TSHIFT      8'h46
`define HB_COND_MINUS        8'h47
`define HB_SUM_HIGH          8'h48
`define HB_SUM_LOW_U         8'h49
`define HB_SUM_TSHIFT        8'h4a
`define HB_XDISJ_MEM         8'h4c
`define HB_DISJ_MEM          8'h4d
`define HB_CONJ_MEM          8'h4e
`define HB_MINUS_BORROW      8'h4f
`define HB_CLEAR_FETCH_HIGH_ROUND 8'h7b
`define TOP5_SAVE_HIGH       5'h0d
`define TOP5_SAVE_LOW        5'h0c
`define WORD_MAGNITUDE       16'hce1b
`define WORD_INVERT_ACC      16'hce27
`define WORD_SIGN_FLIP       16'hce23
`define WORD_ROTATE_LEFT     16'hce34
`define WORD_ROTATE_RIGHT    16'hce35
`define WORD_SHIFT_LEFT      16'hce18
`define WORD_SHIFT_RIGHT     16'hce19
`define TOP5_LOAD_PTR_MEM    5'h06
`define TOP5_SAVE_PTR_MEM    5'h0e
`define TOP5_LOAD_PTR_SHORT  5'h18
`define TOP5_LOAD_PTR_LONG   5'h1a
`define HB_BUMP_PTR          8'h7e
`define HB_PTR_MODIFY        8'h55
`define TOP13_SELECT_PTR     13'h0ab1
`define HB_PAGE_LOAD_MEM     8'h52
`define TOP7_PAGE_LOAD_IMM   7'h64
`define TOP14_PTR_COMPARE    14'h3394
`define LOW_ZERO             8'h00

// Word counts
`define LEN_ONE              2'h1
`define LEN_TWO              2'h2

`endif

// file: tb/fetch_model.sv
// Model of the fetch stage that feeds the decoder one word per cycle.
// Assumes the same rising-edge clock as the decoder.
`timescale 1ns/1ps
`default_nettype none
module fetch_model (
  input wire logic clk,
  output logic word_valid,
  output logic [15:0] word_in
);
  logic [15:0] last_word;
  initial begin
    word_valid = 1'b0;
    word_in = 16'h0000;
    last_word = 16'h0000;
  end
  // Word is taken at the following rising edge
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    word_valid <= 1'b1;
    word_in <= w;
    last_word = w;
  endtask
  // Inverted stale word, so a decoder ignoring valid is caught
  task automatic idle();
    @(posedge clk);
    word_valid <= 1'b0;
    word_in <= ~last_word;
  endtask
endmodule // fetch_model
`default_nettype wire

// file: tb/dec_checker_assertions.sv
// Port-level checks for the instruction decoder.
// Bound to instr_decoder; one clock, rst_b active low.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_consts.vh"
module dec_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic word_valid,
  input wire logic [15:0] word_in,
  input wire logic [8:0] page_pointer,
  input wire logic [2:0] current_ptr_select,
  input wire logic issue_valid,
  input wire logic [5:0] op_code,
  input wire logic [1:0] word_count,
  input wire logic foreign_word,
  input wire logic operand_next,
  input wire logic indirect_mode,
  input wire logic [6:0] addr_field,
  input wire logic [15:0] direct_addr,
  input wire logic [2:0] ptr_select,
  input wire logic [3:0] shift_code,
  input wire logic [15:0] imm_value,
  input wire logic [1:0] compare_mode_field
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic op_take;
  assign op_take = word_valid && !operand_next;
  AST_MEM_FIELDS: assert property (
    op_take && word_in[15:12] == 4'h2 |=> indirect_mode == $past(word_in[7])
    && addr_field == $past(word_in[6:0])) else $error("memory fields wrong");
  AST_SHIFTED: assert property (
    op_take && word_in[15:12] == 4'h0 |=> op_code == `OP_SUM_SHIFTED_MEM
    && shift_code == $past(word_in[11:8]) && word_count == `LEN_ONE) else $error("shifted op wrong");
  AST_LONG_OPCODE: assert property (
    op_take && word_in[15:12] == 4'hd && word_in[7:0] inside {[1:6]}
    |=> operand_next && !issue_valid && !foreign_word) else $error("long opcode not held");
  AST_LONG_ISSUE: assert property (
    operand_next && word_valid |=> issue_valid && word_count == `LEN_TWO
    && imm_value == $past(word_in)) else $error("operand not captured");
  AST_SHORT_IMM: assert property (
    op_take && word_in[15:8] == `HB_SUM_SHORT |=> op_code == `OP_SUM_SHORT_IMM
    && imm_value == {8'h00, $past(word_in[7:0])}) else $error("short immediate wrong");
  AST_SAVE_SHIFT: assert property (
    op_take && word_in[15:11] == `TOP5_SAVE_HIGH |=> op_code == `OP_SAVE_HIGH_ACC
    && shift_code == {1'b0, $past(word_in[10:8])}) else $error("save shift wrong");
  AST_COMPARE: assert property (
    op_take && word_in[15:2] == `TOP14_PTR_COMPARE |=> op_code == `OP_PTR_COMPARE
    && compare_mode_field == $past(word_in[1:0])) else $error("compare mode wrong");
  AST_DIRECT: assert property (
    op_take && word_in[15:12] == 4'h2 |=> direct_addr == {$past(page_pointer),
    $past(word_in[6:0])}) else $error("direct address wrong");
  AST_PTR_SEL: assert property (
    op_take && word_in[15:12] == 4'h1 |=> ptr_select == $past(current_ptr_select))
    else $error("pointer select wrong");
  AST_FOREIGN: assert property (
    op_take && word_in == 16'hce00 |=> foreign_word && !issue_valid) else $error("foreign missed");
  AST_IDLE: assert property (
    !word_valid |=> !issue_valid && !foreign_word) else $error("output without word");
  cover property (operand_next && word_valid ##1 issue_valid);
  cover property (foreign_word);
  cover property (issue_valid ##1 issue_valid);
endmodule // dec_checker
bind instr_decoder dec_checker u_chk (.clk(clk), .rst_b(rst_b), .word_valid(word_valid),
  .word_in(word_in), .page_pointer(page_pointer), .current_ptr_select(current_ptr_select),
  .issue_valid(issue_valid), .op_code(op_code), .word_count(word_count),
  .foreign_word(foreign_word), .operand_next(operand_next), .indirect_mode(indirect_mode),
  .addr_field(addr_field), .direct_addr(direct_addr), .ptr_select(ptr_select),
  .shift_code(shift_code), .imm_value(imm_value), .compare_mode_field(compare_mode_field));
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the instruction decoder.
// Words come from fetch_model; checker is attached by bind.
`timescale 1ns/1ps
`default_nettype none
`include "decoder_consts.vh"
module tb;
  logic clk;
  logic rst_b;
  logic [8:0] page_pointer;
  logic [2:0] current_ptr_select;
  wire word_valid;
  wire [15:0] word_in;
  wire issue_valid;
  wire [5:0] op_code;
  wire [1:0] word_count;
  wire foreign_word;
  wire operand_next;
  wire indirect_mode;
  wire [6:0] addr_field;
  wire [15:0] direct_addr;
  wire [2:0] ptr_select;
  wire [3:0] shift_code;
  wire [15:0] imm_value;
  wire [1:0] compare_mode_field;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // Entry i decodes to op code i
  logic [15:0] words [1:48] = '{16'h0395, 16'h1395, 16'h2f95, 16'hd501, 16'hd702, 16'hd903,
    16'hdd04, 16'hde05, 16'hdf06, 16'hcc5a, 16'hcd5a, 16'hca5a, 16'hca00, 16'h4095, 16'h4195,
    16'h4295, 16'h4395, 16'h4495, 16'h4595, 16'h4695, 16'h4795, 16'h4895, 16'h4995, 16'h4a95,
    16'h4c95, 16'h4d95, 16'h4e95, 16'h4f95, 16'h7b95, 16'h6d95, 16'h6295, 16'hce1b, 16'hce27,
    16'hce23, 16'hce34, 16'hce35, 16'hce18, 16'hce19, 16'h3595, 16'h7395, 16'hc6a5, 16'hd400,
    16'h7e5a, 16'h5595, 16'h558e, 16'h5295, 16'hc9a5, 16'hce52};
  fetch_model fetch (.clk(clk), .word_valid(word_valid), .word_in(word_in));
  instr_decoder DUT (.clk(clk), .rst_b(rst_b), .word_valid(word_valid), .word_in(word_in),
    .page_pointer(page_pointer), .current_ptr_select(current_ptr_select),
    .issue_valid(issue_valid), .op_code(op_code), .word_count(word_count),
    .foreign_word(foreign_word), .operand_next(operand_next), .indirect_mode(indirect_mode),
    .addr_field(addr_field), .direct_addr(direct_addr), .ptr_select(ptr_select),
    .shift_code(shift_code), .imm_value(imm_value), .compare_mode_field(compare_mode_field));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic results();
    if (bad_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Run needs about 160 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic one(input logic [15:0] w);
    fetch.send(w);
    fetch.idle();
    #1;
  endtask
  task automatic t_table();
    for (int i = 1; i <= 48; i++) begin
      fetch.send(words[i]);
      if (words[i][15:12] == 4'hd) fetch.send(16'h5a3c);
      fetch.idle();
      #1;
      chk({10'h000, op_code}, 16'(i));
      chk({14'h0000, word_count}, (words[i][15:12] == 4'hd) ? 16'h2 : 16'h1);
      chk({15'h0000, issue_valid}, 16'h1);
    end
  endtask
  task automatic t_fields();
    @(posedge clk);
    page_pointer <= 9'h1a3;
    current_ptr_select <= 3'h5;
    one(16'h2f95);
    chk({15'h0000, indirect_mode}, 16'h1);
    chk({9'h000, addr_field}, 16'h0015);
    chk(direct_addr, {9'h1a3, 7'h15});
    chk({13'h0000, ptr_select}, 16'h5);
    chk({12'h000, shift_code}, 16'hf);
    one(16'h1e15);
    chk({15'h0000, indirect_mode}, 16'h0);
  endtask
  task automatic t_imm();
    one(16'hcc5a);
    chk(imm_value, 16'h005a);
    one(16'hc9a5);
    chk(imm_value, 16'h01a5);
    one(16'h558e);
    chk({13'h0000, ptr_select}, 16'h6);
    one(16'hce52);
    chk({14'h0000, compare_mode_field}, 16'h2);
    one(16'h6d95);
    chk({12'h000, shift_code}, 16'h5);
    // Field select differs from current_ptr_select so a wrong source shows up
    one(16'h3295);
    chk({13'h0000, ptr_select}, 16'h2);
    one(16'hc6a5);
    chk({ptr_select, imm_value[12:0]}, 16'hc0a5);
    one(16'h7e5a);
    chk(imm_value, 16'h005a);
  endtask
  task automatic t_long();
    fetch.send(16'hd701);
    fetch.send(16'hca00);
    #1;
    chk({14'h0000, operand_next, issue_valid}, 16'h2);
    fetch.send(16'hd400);
    #1;
    chk({10'h000, op_code}, {10'h000, `OP_FETCH_LONG_IMM});
    chk(imm_value, 16'hca00);
    chk({12'h000, shift_code}, 16'h7);
    fetch.send(16'hbeef);
    fetch.idle();
    #1;
    chk({10'h000, op_code}, {10'h000, `OP_LOAD_PTR_REG_LONG});
    chk({ptr_select, imm_value[12:0]}, 16'h9eef);
  endtask
  task automatic t_foreign();
    logic [15:0] fw [0:4];
    fw = '{16'hce00, 16'hd107, 16'h4b95, 16'h3c95, 16'hff80};
    for (int i = 0; i < 5; i++) begin
      one(fw[i]);
      chk({14'h0000, foreign_word, issue_valid}, 16'h2);
    end
  endtask
  initial begin
    rst_b = 1'b0;
    page_pointer = 9'h000;
    current_ptr_select = 3'h0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_table();
    t_fields();
    t_imm();
    t_long();
    t_foreign();
    results();
  end
endmodule // tb
`default_nettype wire
